//--- hw/i2c_nv_setting_mux_latch.sv
// two-wire configuration switch: stored setting, pin mux and held output
// assumes rst_n is the power-on reset; open-drain pins pull low while oe is high
`timescale 1ns/1ps

module i2c_nv_setting_mux_latch
    import nv_setting_pkg::*;
#(
    parameter logic [4:0] ADDR_FIXED = ADDR_FIXED_DEFAULT
) (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe,
    input  wire logic                 addr_strap_1,
    input  wire logic                 addr_strap_0,
    input  wire logic                 path_select,
    input  wire logic                 force_low_n,
    input  wire logic                 nv_write_lock,
    input  wire logic [MUX_WIDTH-1:0] ext_setting_in,
    input  wire logic                 bus_supply_ok,
    input  wire logic                 core_supply_ok,
    output logic      [MUX_WIDTH-1:0] selected_setting_oe,
    output logic                      held_bit_oe
);

    // ************************************************************
    // input synchronisation
    // ************************************************************
    localparam int SYNC_W = MUX_WIDTH + 9;

    logic [SYNC_W-1:0]    raw_pins;
    logic [SYNC_W-1:0]    sync_pins;
    logic                 scl_s;
    logic                 sda_s;
    logic                 strap0_s;
    logic                 strap1_s;
    logic                 sel_s;
    logic                 force_n_s;
    logic                 lock_s;
    logic [MUX_WIDTH-1:0] ext_s;
    logic                 bus_ok_s;
    logic                 core_ok_s;

    assign raw_pins = {core_supply_ok, bus_supply_ok, ext_setting_in, nv_write_lock,
                       force_low_n, path_select, addr_strap_1, addr_strap_0,
                       sda_i, scl_i};

    pin_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clock        (clock),
        .rst_n        (rst_n),
        .pin_raw      (raw_pins),
        .pin_sync_out (sync_pins)
    );

    assign scl_s     = sync_pins[0];
    assign sda_s     = sync_pins[1];
    assign strap0_s  = sync_pins[2];
    assign strap1_s  = sync_pins[3];
    assign sel_s     = sync_pins[4];
    assign force_n_s = sync_pins[5];
    assign lock_s    = sync_pins[6];
    assign ext_s     = sync_pins[MUX_WIDTH+6:7];
    assign bus_ok_s  = sync_pins[MUX_WIDTH+7];
    assign core_ok_s = sync_pins[MUX_WIDTH+8];

    // ************************************************************
    // line events
    // ************************************************************
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    line_events u_events (
        .clock      (clock),
        .rst_n      (rst_n),
        .scl        (scl_s),
        .sda        (sda_s),
        .scl_rise   (scl_rise),
        .scl_fall   (scl_fall),
        .start_seen (start_seen),
        .stop_seen  (stop_seen)
    );

    // ************************************************************
    // stored setting
    // ************************************************************
    // no reset here: the cells stand for non-volatile storage and keep
    // their content across power-on reset
    logic [NV_WIDTH-1:0] nv_q = NV_FACTORY;
    logic                commit;
    logic                write_ok;
    logic [7:0]          read_byte;
    logic                lock_clear;
    logic                supply_good;

    assign lock_clear  = ~lock_s;
    // either supply low blocks writes, so a brown-out cannot corrupt the cells
    assign supply_good = bus_ok_s & core_ok_s;
    assign write_ok    = lock_clear & supply_good;
    assign read_byte   = {2'h0, nv_q};

    // ************************************************************
    // serial engine
    // ************************************************************
    bus_state_e state_q;
    bus_state_e state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic       rw_q;
    logic       rw_d;
    logic       sda_oe_q;
    logic       sda_oe_d;
    logic       addr_hit;
    logic       byte_full;
    logic [6:0] addr_word;
    logic       first_rd_oe;
    logic       next_rd_oe;

    assign addr_word   = {ADDR_FIXED, strap1_s, strap0_s};
    assign addr_hit    = shift_q[7:1] == addr_word;
    assign byte_full   = cnt_q == BYTE_BITS;
    // a zero bit pulls the line low, a one leaves it to the pull-up
    assign first_rd_oe = ~read_byte[7];
    assign next_rd_oe  = ~shift_q[6];

    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        shift_d  = shift_q;
        rw_d     = rw_q;
        sda_oe_d = sda_oe_q;
        commit   = 1'h0;
        if (stop_seen) begin
            state_d  = ST_IDLE;
            sda_oe_d = 1'h0;
        end else if (start_seen) begin
            // a start anywhere reopens address reception
            state_d  = ST_ADDR;
            cnt_d    = 4'h0;
            sda_oe_d = 1'h0;
        end else if (scl_rise) begin
            case (state_q)
                ST_ADDR, ST_WDATA: begin
                    if (!byte_full) begin
                        shift_d = {shift_q[6:0], sda_s};
                        cnt_d   = cnt_q + 4'h1;
                    end
                end
                ST_RDATA: begin
                    if (!byte_full) begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_q)
                ST_ADDR: begin
                    if (byte_full) begin
                        if (addr_hit) begin
                            state_d  = ST_ADDR_ACK;
                            rw_d     = shift_q[0];
                            sda_oe_d = 1'h1;
                        end else begin
                            state_d  = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    cnt_d = 4'h0;
                    if (rw_q) begin
                        state_d  = ST_RDATA;
                        shift_d  = read_byte;
                        sda_oe_d = first_rd_oe;
                    end else begin
                        state_d  = ST_WDATA;
                        sda_oe_d = 1'h0;
                    end
                end
                ST_WDATA: begin
                    if (byte_full) begin
                        commit   = write_ok;
                        state_d  = ST_DATA_ACK;
                        sda_oe_d = 1'h1;
                    end
                end
                ST_RDATA: begin
                    if (byte_full) begin
                        state_d  = ST_DATA_ACK;
                        sda_oe_d = 1'h0;
                    end else begin
                        shift_d  = {shift_q[6:0], 1'h0};
                        sda_oe_d = next_rd_oe;
                    end
                end
                ST_DATA_ACK: begin
                    // one data byte only; further clocks are ignored
                    state_d  = ST_DONE;
                    sda_oe_d = 1'h0;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q  <= ST_IDLE;
            cnt_q    <= 4'h0;
            shift_q  <= 8'h00;
            rw_q     <= 1'h0;
            sda_oe_q <= 1'h0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            shift_q  <= shift_d;
            rw_q     <= rw_d;
            sda_oe_q <= sda_oe_d;
        end
    end

    // ************************************************************
    // commit of the stored setting
    // ************************************************************
    // bits 7:6 of the byte are dropped here; power-on reset leaves
    // the last written value in place
    always_ff @(posedge clock) begin
        if (commit) begin
            nv_q <= shift_q[NV_WIDTH-1:0];
        end
    end

    // ************************************************************
    // output mux and held bit
    // ************************************************************
    logic                 force_zero;
    logic [MUX_WIDTH-1:0] mux_val;
    logic                 live_held;
    logic                 held_val;
    logic                 held_q;
    logic [MUX_WIDTH-1:0] mux_oe_q;
    logic                 held_oe_q;

    assign force_zero = ~force_n_s & ~sel_s;
    assign mux_val    = sel_s ? ext_s : nv_q[MUX_WIDTH-1:0];
    assign live_held  = force_zero ? 1'h0 : nv_q[HELD_BIT];
    assign held_val   = sel_s ? held_q : live_held;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            held_q <= HELD_RESET;
        end else if (!sel_s) begin
            // tracks the shown value, so a rise of select freezes exactly it
            held_q <= live_held;
        end
    end

    // ************************************************************
    // open-drain output stage
    // ************************************************************
    // enable high pulls the pin low; one flop per pin keeps each pad
    // driven straight from a register
    logic [MUX_WIDTH-1:0] mux_pull;

    assign mux_pull = force_zero ? {MUX_WIDTH{1'h1}} : ~mux_val;

    genvar p;
    generate
        for (p = 0; p < MUX_WIDTH; p = p + 1) begin : g_mux_pin
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    mux_oe_q[p] <= 1'h0;
                end else begin
                    mux_oe_q[p] <= mux_pull[p];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            held_oe_q <= 1'h0;
        end else begin
            held_oe_q <= ~held_val;
        end
    end

    assign selected_setting_oe = mux_oe_q;
    assign held_bit_oe         = held_oe_q;
    assign sda_oe              = sda_oe_q;
    assign sda_o               = 1'h0;

endmodule

//--- hw/line_events.sv
// start, stop and clock-edge detection on synchronised serial lines
// assumes both lines already passed a two-flop synchroniser
`timescale 1ns/1ps

module line_events (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_seen,
    output logic      stop_seen
);

    logic scl_prev_q;
    logic sda_prev_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            scl_prev_q <= 1'h1;
            sda_prev_q <= 1'h1;
        end else begin
            scl_prev_q <= scl;
            sda_prev_q <= sda;
        end
    end

    assign scl_rise   =  scl & ~scl_prev_q;
    assign scl_fall   = ~scl &  scl_prev_q;
    // data edges only count while the clock stays high
    assign start_seen = scl & scl_prev_q & sda_prev_q & ~sda;
    assign stop_seen  = scl & scl_prev_q & ~sda_prev_q & sda;

endmodule

//--- hw/nv_setting_pkg.sv
// constants, types and state codes shared by the setting switch design
// assumes a single 100 MHz clock and a synchronous active-low reset
//
// Behaviour
// - select low drives the multiplexed outputs from the stored setting.
// - select high passes the external setting pins to the multiplexed outputs.
// - held output is a latch, transparent while select low, holding while high.
// - override low with select low forces every output to zero.
// - serial writes are accepted only while the write lock is low.
// - lock high means no incoming write data reaches the stored setting.
// - stored setting is all zeros as delivered, before any write.
// - override, lock, external pins and select read as one when undriven.
// - each transaction opens with an address byte; only a valid one answers.
// - address is five fixed bits, two strap bits, then a direction bit.
// - after the address acknowledge exactly one data byte is transferred.
// - direction zero writes, gated by the lock; direction one reads back.
// - high-order data bits map to the held output, low-order to multiplexed.
// - writes are blocked while bus or core supply is not good.
// - power-on reset returns the volatile state and bus engine to defaults.
// - held output keeps the value shown when select rose low to high.
// - stored setting survives power loss; last written value is used.
// - stored setting is six bits wide.
// - five multiplexed open-drain outputs and one held open-drain output.

package nv_setting_pkg;

    // ************************************************************
    // widths and layout
    // ************************************************************
    localparam int          NV_WIDTH   = 6;
    localparam int          MUX_WIDTH  = 5;
    localparam int          HELD_BIT   = 5;
    localparam int          FIXED_BITS = 5;
    localparam logic [3:0]  BYTE_BITS  = 4'h8;

    // ************************************************************
    // initial, reset and default values
    // ************************************************************
    localparam logic [5:0]  NV_FACTORY   = 6'h00;
    localparam logic        HELD_RESET   = 1'h0;
    localparam logic        PIN_IDLE     = 1'h1;
    // arbitrary value for the fixed address bits
    localparam logic [4:0]  ADDR_FIXED_DEFAULT = 5'h13;

    // ************************************************************
    // serial engine states
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_ADDR     = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_WDATA    = 3'b011,
        ST_RDATA    = 3'b100,
        ST_DATA_ACK = 3'b101,
        ST_DONE     = 3'b110
    } bus_state_e;

endpackage

//--- hw/pin_sync.sv
// two-stage synchroniser for a group of asynchronous pins
// assumes pins with pull-ups, so the flops reset to ones
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pin_raw,
    output logic      [WIDTH-1:0] pin_sync_out
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    stage1_q[i] <= 1'h1;
                    stage2_q[i] <= 1'h1;
                end else begin
                    stage1_q[i] <= pin_raw[i];
                    stage2_q[i] <= stage1_q[i];
                end
            end
        end
    endgenerate

    assign pin_sync_out = stage2_q;

endmodule

//--- test/i2c_master_model.sv
// two-wire bus master model: drives the serial clock, pulls data low
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps

module i2c_master_model (
    input  wire logic clock,
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_in
);
    // clock phase in cycles; 4 gives the 80 ns link period, more is a slow master
    int ph = 4;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // data moves two cycles after the fall, clear of the clock edge
    task automatic bit_io(input logic b, output logic r);
        repeat (2) @(posedge clock);
        sda_low <= !b;
        repeat (ph - 2) @(posedge clock);
        scl <= 1'b1;
        repeat (ph) @(posedge clock);
        r = sda_in;
        scl <= 1'b0;
    endtask

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(1'b1, a);
        ack = !a;
    endtask

    task automatic access(input logic [7:0] ab, input logic [7:0] wd, input logic extra,
                          output logic [2:0] acks, output logic [7:0] rd);
        logic [7:0] junk;
        acks = 3'h0;
        rd = 8'h00;
        @(posedge clock);
        sda_low <= 1'b1;
        repeat (ph) @(posedge clock);
        scl <= 1'b0;
        xfer(ab, junk, acks[0]);
        if (acks[0]) begin
            xfer(ab[0] ? 8'hFF : wd, rd, acks[1]);
            if (extra) xfer(wd, junk, acks[2]);
        end
        repeat (2) @(posedge clock);
        sda_low <= 1'b1;
        repeat (ph - 2) @(posedge clock);
        scl <= 1'b1;
        repeat (ph) @(posedge clock);
        sda_low <= 1'b0;
        repeat (ph) @(posedge clock);
    endtask
endmodule

//--- test/i2c_nv_setting_mux_latch_test.sv
// self-checking bench: straps, lock, supplies, mux and held output
// assumes the master model and the bound checker are compiled first
`timescale 1ns/1ps

module i2c_nv_setting_mux_latch_test;
    import nv_setting_pkg::*;
    logic        clock   = 1'b0;
    logic        rst_n   = 1'b0;
    logic        sel     = 1'b1;
    logic        frc     = 1'b1;
    logic        lock    = 1'b1;
    logic        bus_ok  = 1'b1;
    logic        core_ok = 1'b1;
    logic [1:0]  straps  = 2'b11;
    logic [4:0]  ext     = 5'h1F;
    logic [5:0]  model_q = 6'h00;
    logic [31:0] rng     = 32'h11EA;
    logic        scl, m_low, sda_o, sda_oe, held_oe;
    logic [4:0]  sel_oe;
    logic [7:0]  rd, wd;
    logic [2:0]  acks;
    int          err_count   = 0;
    int          comparisons = 0;
    wire         sda = !(m_low || sda_oe);

    always #5 clock = ~clock;

    i2c_nv_setting_mux_latch uut (
        .clock(clock), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_strap_1(straps[1]), .addr_strap_0(straps[0]),
        .path_select(sel), .force_low_n(frc), .nv_write_lock(lock), .ext_setting_in(ext),
        .bus_supply_ok(bus_ok), .core_supply_ok(core_ok), .selected_setting_oe(sel_oe),
        .held_bit_oe(held_oe)
    );
    i2c_master_model master (.clock(clock), .scl(scl), .sda_low(m_low), .sda_in(sda));

    function automatic logic [7:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[7:0];
    endfunction

    function automatic logic [7:0] addr(input logic [1:0] s, input logic rw);
        return {ADDR_FIXED_DEFAULT, s, rw};
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic outs(input logic [5:0] exp, input string what);
        // look after the edge's updates have landed
        #1;
        check({2'b00, held_oe, sel_oe}, {2'b00, exp}, what);
    endtask

    task automatic pins(input logic s, input logic f, input logic [4:0] e);
        @(posedge clock);
        sel <= s;
        frc <= f;
        ext <= e;
        repeat (8) @(posedge clock);
    endtask

    task automatic store(input logic [7:0] d);
        model_q = d[5:0];
        master.access(addr(straps, 1'b0), d, 1'b0, acks, rd);
        check({5'h00, acks}, 8'h03, "write acks");
    endtask

    task automatic read_back(input string what);
        master.access(addr(straps, 1'b1), 8'h00, 1'b0, acks, rd);
        check(rd, {2'b00, model_q}, what);
    endtask

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        // held latch restarts at zero while select sits high, so its pin pulls low
        outs(6'h20, "pulled-up pins after reset");
        @(posedge clock);
        lock <= 1'b0;
        pins(1'b0, 1'b1, 5'h1F);
        read_back("factory contents");
        for (int s = 0; s < 4; s++) begin
            @(posedge clock);
            straps <= s[1:0];
            repeat (4) @(posedge clock);
            wd = rnd();
            model_q = wd[5:0];
            master.access(addr(straps, 1'b0), wd, 1'b1, acks, rd);
            check({5'h00, acks}, 8'h03, "surplus byte refused");
            master.access(addr(straps ^ 2'b01, 1'b0), ~wd, 1'b0, acks, rd);
            check({5'h00, acks}, 8'h00, "strap mismatch");
            master.access({ADDR_FIXED_DEFAULT ^ 5'h10, straps, 1'b0}, ~wd, 1'b0, acks, rd);
            check({5'h00, acks}, 8'h00, "fixed bits mismatch");
            read_back("stored value");
            outs(~model_q, "register drives outputs");
        end
        $display("test straps and writes done");
        for (int k = 0; k < 3; k++) begin
            @(posedge clock);
            lock <= (k == 0);
            bus_ok <= (k != 1);
            core_ok <= (k != 2);
            repeat (4) @(posedge clock);
            master.access(addr(straps, 1'b0), ~{2'b00, model_q}, 1'b0, acks, rd);
            read_back("blocked write");
        end
        @(posedge clock);
        lock <= 1'b0;
        bus_ok <= 1'b1;
        core_ok <= 1'b1;
        $display("test write blocking done");
        store(rnd() | 8'h20);
        for (int i = 0; i < 4; i++) begin
            pins(1'b1, 1'b1, 5'(rnd()));
            outs({1'b0, ~ext}, "pins pass through");
        end
        store(rnd() & 8'hDF);
        outs({1'b0, ~ext}, "held keeps while selected high");
        pins(1'b1, 1'b0, ext);
        outs({1'b0, ~ext}, "override with select high");
        pins(1'b0, 1'b0, ext);
        outs(6'h3F, "override forces low");
        pins(1'b1, 1'b0, ext);
        outs({1'b1, ~ext}, "held captured override");
        pins(1'b0, 1'b1, ext);
        outs(~model_q, "back to register");
        $display("test mux and held done");
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        read_back("kept through reset");
        outs(~model_q, "register after reset");
        $display("test power cycle done");
        master.ph = 6;
        store(rnd());
        read_back("slow master");
        $display("test slow master done");
        end_sim();
    end

    initial begin
        #500us;
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule

//--- test/nv_setting_asserts.sv
// checker for the setting switch, watching only the top-level ports
// assumes one clock domain with synchronous active-low reset; bound below
`timescale 1ns/1ps

module nv_setting_checker
    import nv_setting_pkg::*;
(
    input wire logic                 clock,
    input wire logic                 rst_n,
    input wire logic                 scl_i,
    input wire logic                 sda_i,
    input wire logic                 sda_o,
    input wire logic                 sda_oe,
    input wire logic                 path_select,
    input wire logic                 force_low_n,
    input wire logic                 nv_write_lock,
    input wire logic [MUX_WIDTH-1:0] ext_setting_in,
    input wire logic                 bus_supply_ok,
    input wire logic                 core_supply_ok,
    input wire logic [MUX_WIDTH-1:0] selected_setting_oe,
    input wire logic                 held_bit_oe
);
    // ************************************************************
    // age since reset; synchronisers start at ones, so wait them out
    // ************************************************************
    logic [2:0] age_q;
    wire        settled = (age_q == 3'h7);
    wire        blocked = nv_write_lock || !bus_supply_ok || !core_supply_ok;

    always_ff @(posedge clock) begin
        if (!rst_n) age_q <= 3'h0;
        else if (!settled) age_q <= age_q + 3'h1;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ************************************************************
    // properties
    // ************************************************************
    property p_override;
        (settled && !force_low_n && !path_select)[*4] |-> (&selected_setting_oe) && held_bit_oe;
    endproperty
    property p_ext_pass;
        (settled && path_select && $stable(ext_setting_in))[*4]
            |-> selected_setting_oe == ~ext_setting_in;
    endproperty
    property p_held_hold;
        (settled && path_select)[*6] |-> $stable(held_bit_oe);
    endproperty
    property p_held_capture;
        (settled && !force_low_n && !path_select)[*4] ##1 path_select[*5] |-> held_bit_oe;
    endproperty
    property p_lock_freeze;
        (settled && blocked && !path_select && force_low_n)[*6]
            |-> $stable(selected_setting_oe) && $stable(held_bit_oe);
    endproperty
    property p_bus_idle;
        (settled && scl_i)[*8] |-> !sda_oe;
    endproperty
    property p_sda_value;
        sda_o == 1'b0;
    endproperty
    property p_reset_state;
        $rose(rst_n) |-> !sda_oe && selected_setting_oe == 5'h00 && !held_bit_oe;
    endproperty

    a_override:     assert property (p_override) else $error("override did not force low");
    a_ext_pass:     assert property (p_ext_pass) else $error("pins not passed through");
    a_held_hold:    assert property (p_held_hold) else $error("held output moved");
    a_held_capture: assert property (p_held_capture) else $error("capture not zero");
    a_lock_freeze:  assert property (p_lock_freeze) else $error("blocked write landed");
    a_bus_idle:     assert property (p_bus_idle) else $error("data line held while idle");
    a_sda_value:    assert property (p_sda_value) else $error("data driven high");
    a_reset_state:  assert property (p_reset_state) else $error("outputs not released");

    c_ack:     cover property ($rose(sda_oe));
    c_capture: cover property (!force_low_n && !path_select ##1 path_select);
    c_blocked: cover property (blocked && !path_select && !scl_i);
endmodule

bind i2c_nv_setting_mux_latch nv_setting_checker chk (
    .clock, .rst_n, .scl_i, .sda_i, .sda_o, .sda_oe, .path_select, .force_low_n,
    .nv_write_lock, .ext_setting_in, .bus_supply_ok, .core_supply_ok,
    .selected_setting_oe, .held_bit_oe
);
